// file: verilog/dual_timer.sv
// dual 16-bit timer joined as 32-bit one-shot/periodic timer or 32-bit rtc
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
module dual_timer
   import dual_timer_pkg::*;
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst,
   // register port
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr_stb,
   input  wire logic        rd_stb,
   output logic      [31:0] rdata,
   // capture pins and stall request
   input  wire logic        ccp_even,
   input  wire logic        ccp_odd,
   input  wire logic        stall_req,
   // outputs
   output logic             adc_trigger,
   output logic             irq
);
   timer_state_t s_r;
   timer_state_t s_nxt;
   bus_req_t     req;
   logic         mode32;
   logic         rtc_mode;
   logic [31:0]  cnt32;
   logic [31:0]  load32;
   logic [31:0]  match32;
   logic         lo_run;
   logic         hi_run;
   logic         lo_zero;
   logic         hi_zero;
   logic         z32;
   logic         rtc_tick;
   logic         rtc_hit;
   logic         lo_frz;
   logic         hi_frz;
   logic         ccp_rise;
   logic [8:0]  masked;
   logic [8:0]  set_ev;

   assign req = '{addr: addr, wdata: wdata, wr: wr_stb, rd: rd_stb};
   //////////////////////////////////////////////////////////////////////////
   // decode of mode and counter conditions
   // mode selection
   assign mode32   = (s_r.cfg == CFG_32_TIMER) || (s_r.cfg == CFG_32_RTC);
   assign rtc_mode = (s_r.cfg == CFG_32_RTC);
   assign cnt32    = {s_r.hi_cnt, s_r.lo_cnt};
   assign load32   = {s_r.hi_load, s_r.lo_load};
   assign match32  = {16'h0000, s_r.lo_match};
   assign lo_run   = s_r.ctl[CTL_LOW_EN];
   assign hi_run   = s_r.ctl[CTL_HIGH_EN];
   assign z32      = (cnt32 == ZERO32);
   assign lo_zero  = (s_r.lo_cnt == 16'h0000);
   assign hi_zero  = (s_r.hi_cnt == 16'h0000);
   // stall freezes unless rtc enabled; rtc overrides stall
   assign lo_frz = stall_req && s_r.ctl[CTL_LOW_STALL] && !s_r.ctl[CTL_RTC_EN];
   assign hi_frz = stall_req && s_r.ctl[CTL_HIGH_STALL] && !s_r.ctl[CTL_RTC_EN];
   // even pin feeds the rtc; odd pin is reserved for 16-bit capture modes
   assign ccp_rise = ccp_even && !s_r.ccp_prev;
   // 1 Hz tick after 32768 input rises
   assign rtc_tick = rtc_mode && lo_run && ccp_rise && (s_r.rtc_div == RTC_DIV_LAST);
   assign rtc_hit  = rtc_tick && (cnt32 == match32);
   assign masked   = s_r.raw & s_r.imask;

   //////////////////////////////////////////////////////////////////////////
   // next-state logic
   always_comb begin
      s_nxt      = s_r;
      s_nxt.trig = 1'b0;
      s_nxt.ccp_prev = ccp_even;
      set_ev     = 9'h000;
      s_nxt.rdata = 32'h00000000;
      // register writes
      if (req.wr) begin
         case (req.addr)
            OFS_CONFIG: begin
               s_nxt.cfg = req.wdata[2:0];
            end
            OFS_LOW_MODE: begin
               s_nxt.lo_mode = req.wdata[1:0];
            end
            OFS_HIGH_MODE: begin
               s_nxt.hi_mode = req.wdata[1:0];
            end
            OFS_CONTROL: begin
               s_nxt.ctl = req.wdata[13:0];
            end
            OFS_MASK: begin
               s_nxt.imask = req.wdata[8:0];
            end
            OFS_LOW_LOAD: begin
               s_nxt.lo_load = req.wdata[15:0];
               // joined write fills the high load
               if (mode32) begin
                  s_nxt.hi_load = req.wdata[31:16];
               end
            end
            OFS_HIGH_LOAD: begin
               s_nxt.hi_load = req.wdata[15:0];
            end
            OFS_LOW_MATCH: begin
               s_nxt.lo_match = req.wdata[15:0];
            end
            OFS_LOW_PRE: begin
               s_nxt.lo_pre = req.wdata[7:0];
            end
            OFS_HIGH_PRE: begin
               s_nxt.hi_pre = req.wdata[7:0];
            end
            default: begin
            end
         endcase
      end
      // rtc divider runs only in rtc mode while the low enable is set
      if (rtc_mode && lo_run && ccp_rise) begin
         s_nxt.rtc_div = (s_r.rtc_div == RTC_DIV_LAST) ? 15'h0000 : s_r.rtc_div + 15'h0001;
      end
      if (rtc_mode) begin
         // first entry into rtc loads one
         if (!s_r.rtc_seen) begin
            s_nxt.rtc_seen = 1'b1;
            {s_nxt.hi_cnt, s_nxt.lo_cnt} = RTC_FIRST;
         // match rolls to zero and flags
         end else if (rtc_hit) begin
            {s_nxt.hi_cnt, s_nxt.lo_cnt} = ZERO32;
            set_ev[ST_RTC] = 1'b1;
         end else if (rtc_tick) begin
            {s_nxt.hi_cnt, s_nxt.lo_cnt} = cnt32 + 32'h00000001;
         end
      end else if (mode32) begin
         // new load taken next cycle while running
         if (req.wr && req.addr == OFS_LOW_LOAD && lo_run) begin
            {s_nxt.hi_cnt, s_nxt.lo_cnt} = req.wdata;
         // reload after zero, count down otherwise
         end else if (lo_run && !lo_frz) begin
            if (z32) begin
               {s_nxt.hi_cnt, s_nxt.lo_cnt} = load32;
            end else begin
               {s_nxt.hi_cnt, s_nxt.lo_cnt} = cnt32 - 32'h00000001;
               if (cnt32 == 32'h00000001) begin
                  set_ev[ST_LOW_TO] = 1'b1;
                  s_nxt.trig = s_r.ctl[CTL_LOW_OTE];
                  // one-shot clears enable; only low mode field decides
                  if (s_r.lo_mode == MODE_ONESHOT) begin
                     s_nxt.ctl[CTL_LOW_EN] = 1'b0;
                  end
               end
            end
         end
      end else begin
         // split mode: two independent 16-bit down counters
         if (req.wr && req.addr == OFS_LOW_LOAD && lo_run) begin
            s_nxt.lo_cnt = req.wdata[15:0];
         end else if (lo_run && !lo_frz) begin
            s_nxt.lo_cnt = lo_zero ? s_r.lo_load : s_r.lo_cnt - 16'h0001;
            if (s_r.lo_cnt == 16'h0001) begin
               set_ev[ST_LOW_TO] = 1'b1;
               s_nxt.trig = s_r.ctl[CTL_LOW_OTE];
               if (s_r.lo_mode == MODE_ONESHOT) begin
                  s_nxt.ctl[CTL_LOW_EN] = 1'b0;
               end
            end
         end
         if (req.wr && req.addr == OFS_HIGH_LOAD && hi_run) begin
            s_nxt.hi_cnt = req.wdata[15:0];
         end else if (hi_run && !hi_frz) begin
            s_nxt.hi_cnt = hi_zero ? s_r.hi_load : s_r.hi_cnt - 16'h0001;
            if (s_r.hi_cnt == 16'h0001) begin
               set_ev[ST_HIGH_TO] = 1'b1;
               s_nxt.trig = s_nxt.trig | s_r.ctl[CTL_HIGH_OTE];
               if (s_r.hi_mode == MODE_ONESHOT) begin
                  s_nxt.ctl[CTL_HIGH_EN] = 1'b0;
               end
            end
         end
      end
      // leaving rtc mode lets the next entry load one again
      if (!rtc_mode) begin
         s_nxt.rtc_seen = 1'b0;
      end
      // clear by write, set wins over clear; rtc clear bit
      if (req.wr && req.addr == OFS_CLEAR) begin
         s_nxt.raw = s_r.raw & ~req.wdata[8:0];
      end
      s_nxt.raw = s_nxt.raw | set_ev;
      // reads answer one cycle later; unmapped reads give zero
      if (req.rd) begin
         case (req.addr)
            OFS_CONFIG:    s_nxt.rdata = {29'h0, s_r.cfg};
            OFS_LOW_MODE:  s_nxt.rdata = {30'h0, s_r.lo_mode};
            OFS_HIGH_MODE: s_nxt.rdata = {30'h0, s_r.hi_mode};
            OFS_CONTROL:   s_nxt.rdata = {18'h0, s_r.ctl};
            OFS_MASK:      s_nxt.rdata = {23'h0, s_r.imask};
            OFS_RAW:       s_nxt.rdata = {23'h0, s_r.raw};
            OFS_MASKED:    s_nxt.rdata = {23'h0, masked};
            OFS_LOW_LOAD:  s_nxt.rdata = mode32 ? load32 : {16'h0, s_r.lo_load};
            OFS_HIGH_LOAD: s_nxt.rdata = {16'h0, s_r.hi_load};
            OFS_LOW_MATCH: s_nxt.rdata = {16'h0, s_r.lo_match};
            OFS_LOW_PRE:   s_nxt.rdata = {24'h0, s_r.lo_pre};
            OFS_HIGH_PRE:  s_nxt.rdata = {24'h0, s_r.hi_pre};
            OFS_LOW_VAL:   s_nxt.rdata = mode32 ? cnt32 : {16'h0, s_r.lo_cnt};
            OFS_HIGH_VAL:  s_nxt.rdata = {16'h0, s_r.hi_cnt};
            default:       s_nxt.rdata = 32'h00000000;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge mclk) begin
      if (rst) begin
         // idle with defaults; counters and loads FFFF, prescale 00
         s_r         <= '0;
         s_r.lo_load <= RST_COUNT;
         s_r.hi_load <= RST_COUNT;
         s_r.lo_cnt  <= RST_COUNT;
         s_r.hi_cnt  <= RST_COUNT;
         s_r.lo_pre  <= RST_PRE;
         s_r.hi_pre  <= RST_PRE;
      end else begin
         s_r <= s_nxt;
      end
   end

   // outputs; trigger is ORed with other blocks outside
   assign rdata       = s_r.rdata;
   assign adc_trigger = s_r.trig;
   // interrupt from any masked flag; includes rtc
   assign irq         = |masked;

   //////////////////////////////////////////////////////////////////////////
   // checks
   // one joined step from one to zero: flag, trigger and one-shot stop all hang on it
   sequence s_hit_zero;
      mode32 && !rtc_mode && lo_run && !lo_frz && !req.wr && cnt32 == 32'h00000001;
   endsequence
   // first cycle in rtc mode, before the counter has been seeded
   sequence s_rtc_entry;
      rtc_mode && !s_r.rtc_seen;
   endsequence
   a_reset_counts: assert property (@(posedge mclk)
      $fell(rst) |-> s_r.lo_cnt == RST_COUNT && s_r.lo_load == RST_COUNT)
      else $error("reset values wrong");
   a_trig_one_cycle: assert property (@(posedge mclk) disable iff (rst) adc_trigger |=> !adc_trigger)
      else $error("trigger longer than one cycle");
   a_timeout_flag: assert property (@(posedge mclk) disable iff (rst) s_hit_zero |=> s_r.raw[ST_LOW_TO])
      else $error("timeout flag not set");
   a_oneshot_stop: assert property (@(posedge mclk) disable iff (rst)
      s_hit_zero ##0 (s_r.lo_mode == MODE_ONESHOT) |=> !lo_run)
      else $error("one-shot did not stop");
   a_trig_at_zero: assert property (@(posedge mclk) disable iff (rst)
      s_hit_zero ##0 s_r.ctl[CTL_LOW_OTE] |=> adc_trigger)
      else $error("no trigger at zero");
   a_reload_zero: assert property (@(posedge mclk) disable iff (rst)
      (mode32 && !rtc_mode && lo_run && !lo_frz && z32 && !req.wr) |=> cnt32 == $past(load32))
      else $error("no reload at zero");
   a_load_running: assert property (@(posedge mclk) disable iff (rst)
      (mode32 && !rtc_mode && lo_run && req.wr && req.addr == OFS_LOW_LOAD) |=> cnt32 == $past(req.wdata))
      else $error("running counter missed new load");
   a_stall_hold: assert property (@(posedge mclk) disable iff (rst)
      (mode32 && !rtc_mode && lo_frz && !req.wr) |=> $stable(cnt32))
      else $error("counter moved during stall");
   a_split_high: assert property (@(posedge mclk) disable iff (rst)
      (!mode32 && hi_run && !hi_frz && !req.wr && s_r.hi_cnt == 16'h0001) |=> s_r.raw[ST_HIGH_TO])
      else $error("high half timeout flag not set");
   a_rtc_first: assert property (@(posedge mclk) disable iff (rst) s_rtc_entry |=> cnt32 == RTC_FIRST)
      else $error("rtc entry did not load one");
   a_rtc_roll: assert property (@(posedge mclk) disable iff (rst)
      (rtc_hit && s_r.rtc_seen) |=> cnt32 == ZERO32 && s_r.raw[ST_RTC])
      else $error("rtc did not roll over");
   // written per flag so that a broken mask vector shows up
   a_irq_masked: assert property (@(posedge mclk) disable iff (rst)
      irq == ((s_r.raw[ST_LOW_TO] && s_r.imask[ST_LOW_TO]) || (s_r.raw[ST_RTC] && s_r.imask[ST_RTC])
              || (s_r.raw[ST_HIGH_TO] && s_r.imask[ST_HIGH_TO])))
      else $error("irq differs from masked status");
   a_joined_load: assert property (@(posedge mclk) disable iff (rst)
      (req.wr && req.addr == OFS_LOW_LOAD && mode32) |=> s_r.hi_load == $past(wdata[31:16]))
      else $error("high load not written");
   a_clear_flag: assert property (@(posedge mclk) disable iff (rst)
      (req.wr && req.addr == OFS_CLEAR && wdata[ST_RTC] && !rtc_hit) |=> !s_r.raw[ST_RTC])
      else $error("rtc flag not cleared");
endmodule

// file: inc/dual_timer_pkg.sv
// constants, register map and carrier types for the dual 16-bit timer block
package dual_timer_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CONFIG   = 8'h00;
   localparam logic [7:0] OFS_LOW_MODE = 8'h04;
   localparam logic [7:0] OFS_HIGH_MODE= 8'h08;
   localparam logic [7:0] OFS_CONTROL  = 8'h0C;
   localparam logic [7:0] OFS_MASK     = 8'h18;
   localparam logic [7:0] OFS_RAW      = 8'h1C;
   localparam logic [7:0] OFS_MASKED   = 8'h20;
   localparam logic [7:0] OFS_CLEAR    = 8'h24;
   localparam logic [7:0] OFS_LOW_LOAD = 8'h28;
   localparam logic [7:0] OFS_HIGH_LOAD= 8'h2C;
   localparam logic [7:0] OFS_LOW_MATCH= 8'h30;
   localparam logic [7:0] OFS_LOW_PRE  = 8'h38;
   localparam logic [7:0] OFS_HIGH_PRE = 8'h3C;
   localparam logic [7:0] OFS_LOW_VAL  = 8'h48;
   localparam logic [7:0] OFS_HIGH_VAL = 8'h4C;
   // configuration codes
   localparam logic [2:0] CFG_32_TIMER = 3'h0;
   localparam logic [2:0] CFG_32_RTC   = 3'h1;
   localparam logic [2:0] CFG_16_SPLIT = 3'h4;
   // mode field codes for both counter halves
   localparam logic [1:0] MODE_ONESHOT = 2'h1;
   localparam logic [1:0] MODE_PERIODIC= 2'h2;
   // control bit positions
   localparam int CTL_LOW_EN    = 0;
   localparam int CTL_LOW_STALL = 1;
   localparam int CTL_RTC_EN    = 4;
   localparam int CTL_LOW_OTE   = 5;
   localparam int CTL_HIGH_EN   = 8;
   localparam int CTL_HIGH_STALL= 9;
   localparam int CTL_HIGH_OTE  = 13;
   // status bit positions
   localparam int ST_LOW_TO  = 0;
   localparam int ST_RTC     = 3;
   localparam int ST_HIGH_TO = 8;
   // reset values
   localparam logic [15:0] RST_COUNT  = 16'hFFFF;
   localparam logic [7:0]  RST_PRE    = 8'h00;
   localparam logic [31:0] RTC_FIRST  = 32'h00000001;
   localparam logic [31:0] ZERO32     = 32'h00000000;
   // rtc divider: 32768 input edges per second
   localparam int RTC_IN_HZ  = 32768;
   localparam int RTC_OUT_HZ = 1;
   localparam int RTC_DIV    = RTC_IN_HZ / RTC_OUT_HZ;
   localparam logic [14:0] RTC_DIV_LAST = 15'(RTC_DIV - 1);

   // register bus request
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } bus_req_t;

   // whole block state
   typedef struct packed {
      logic [2:0]  cfg;
      logic [1:0]  lo_mode;
      logic [1:0]  hi_mode;
      logic [13:0] ctl;
      logic [8:0]  imask;
      logic [8:0]  raw;
      logic [15:0] lo_load;
      logic [15:0] hi_load;
      logic [15:0] lo_match;
      logic [7:0]  lo_pre;
      logic [7:0]  hi_pre;
      logic [15:0] lo_cnt;
      logic [15:0] hi_cnt;
      logic [14:0] rtc_div;
      logic        rtc_seen;
      logic        ccp_prev;
      logic        trig;
      logic [31:0] rdata;
   } timer_state_t;
endpackage

// file: test/rtc_source.sv
// stand-in for the 32.768 kHz source that feeds the even capture pin
`timescale 1ns/10ps
module rtc_source (
   // clock and control
   input  wire logic mclk,
   input  wire logic run,
   // capture pin
   output logic      capture_compare_pin
);
   // toggles every mclk so the fixed 32768-edge divider fits the run; idles low
   // external rtc clock
   always @(posedge mclk) begin
      if (run) begin
         capture_compare_pin <= ~capture_compare_pin;
      end else begin
         capture_compare_pin <= 1'b0;
      end
   end
endmodule

// file: test/tb_dual_timer.sv
// self-checking bench for the dual timer block
`timescale 1ns/10ps
module tb_dual_timer;
   import dual_timer_pkg::*;
   logic        mclk        = 1'b0;
   logic        rst         = 1'b1;
   logic [7:0]  addr        = 8'h00;
   logic [31:0] wdata       = 32'h00000000;
   logic        wr_stb      = 1'b0;
   logic        rd_stb      = 1'b0;
   logic        ccp_odd     = 1'b0;
   logic        stall_req   = 1'b0;
   logic        rtc_run     = 1'b0;
   logic        trig_d      = 1'b0;
   logic [31:0] rdata;
   logic        ccp_even;
   logic        adc_trigger;
   logic        irq;
   logic [31:0] d;
   logic [31:0] d2;
   logic [31:0] mdl_load;
   int          error_cnt   = 0;
   int          comparisons = 0;
   int          seed        = 29;
   int          cyc         = 0;
   int          mdl_n;
   int          i;
   int          trig_q[$];
   logic [2:0]  codes[2]    = '{CFG_16_SPLIT, CFG_32_TIMER};

   always #10 mclk = ~mclk;

   dual_timer u_dual_timer (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
      .rd_stb(rd_stb), .rdata(rdata), .ccp_even(ccp_even), .ccp_odd(ccp_odd), .stall_req(stall_req),
      .adc_trigger(adc_trigger), .irq(irq));
   rtc_source u_rtc_source (.mclk(mclk), .run(rtc_run), .capture_compare_pin(ccp_even));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge mclk);
      addr <= a;
      wdata <= v;
      wr_stb <= 1'b1;
      @(posedge mclk);
      wr_stb <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge mclk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge mclk);
      rd_stb <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string msg);
      rd(a, d);
      chk(d, exp, msg);
   endtask
   task automatic final_report;
      $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // trigger log; the odd pin gets noise since no mode here may look at it
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      trig_d <= adc_trigger;
      ccp_odd <= $random(seed);
      if (adc_trigger === 1'b1) trig_q.push_back(cyc);
      if (adc_trigger === 1'b1 && trig_d === 1'b1) chk(32'h1, 32'h0, "trigger wider than a cycle");
   end

   // watchdog: the rtc tick alone needs some 65536 cycles
   initial begin
      repeat (90000) @(posedge mclk);
      error_cnt++;
      final_report;
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      rchk(OFS_CONFIG, 32'h0, "config after reset");
      rchk(OFS_CONTROL, 32'h0, "control after reset");
      rchk(OFS_LOW_LOAD, 32'hFFFFFFFF, "joined load after reset");
      rchk(OFS_LOW_VAL, 32'hFFFFFFFF, "joined count after reset");
      rchk(OFS_LOW_PRE, 32'h0, "low prescale after reset");
      rchk(OFS_HIGH_PRE, 32'h0, "high prescale after reset");
      rchk(8'hFC, 32'h0, "unmapped read");
      chk({31'h0, irq}, 32'h0, "irq after reset");
      // mode codes read back as written
      foreach (codes[k]) begin
         wr(OFS_CONFIG, {29'h0, codes[k]});
         rchk(OFS_CONFIG, {29'h0, codes[k]}, "config code");
      end
      // joined load write splits into both halves
      mdl_load = $random(seed);
      wr(OFS_LOW_LOAD, mdl_load);
      rchk(OFS_LOW_LOAD, mdl_load, "joined load");
      rchk(OFS_HIGH_LOAD, {16'h0, mdl_load[31:16]}, "high load half");
      // one-shot; the high mode says periodic and must be ignored
      mdl_n = 20 + ($random(seed) & 15);
      wr(OFS_MASK, 32'h1);
      wr(OFS_LOW_MODE, {30'h0, MODE_ONESHOT});
      wr(OFS_HIGH_MODE, {30'h0, MODE_PERIODIC});
      trig_q.delete();
      wr(OFS_CONTROL, 32'h21);
      wr(OFS_LOW_LOAD, mdl_n);
      repeat (mdl_n + 10) @(posedge mclk);
      chk(trig_q.size(), 32'h1, "one-shot pulse count");
      rchk(OFS_RAW, 32'h1, "raw timeout");
      rchk(OFS_MASKED, 32'h1, "masked timeout");
      chk({31'h0, irq}, 32'h1, "irq on masked timeout");
      rchk(OFS_CONTROL, 32'h20, "enable cleared by one-shot");
      rd(OFS_LOW_VAL, d2);
      rchk(OFS_LOW_VAL, d2, "one-shot count stopped");
      wr(OFS_CLEAR, 32'h1);
      rchk(OFS_RAW, 32'h0, "raw after clear");
      chk({31'h0, irq}, 32'h0, "irq after clear");
      // periodic with the mask off: reload period is load plus one
      wr(OFS_MASK, 32'h0);
      wr(OFS_LOW_MODE, {30'h0, MODE_PERIODIC});
      wr(OFS_CONTROL, 32'h21);
      wr(OFS_LOW_LOAD, mdl_n);
      trig_q.delete();
      repeat (3 * (mdl_n + 1) + 10) @(posedge mclk);
      if (trig_q.size() < 2) begin
         chk(trig_q.size(), 32'h2, "periodic pulse count");
      end else begin
         chk(trig_q[$] - trig_q[$-1], mdl_n + 1, "reload period");
      end
      rchk(OFS_RAW, 32'h1, "raw with mask off");
      rchk(OFS_MASKED, 32'h0, "masked with mask off");
      chk({31'h0, irq}, 32'h0, "irq with mask off");
      // trigger disabled: no pulses
      wr(OFS_CONTROL, 32'h01);
      // a pulse launched in the write cycle still used the old enable
      repeat (2) @(posedge mclk);
      trig_q.delete();
      repeat (2 * (mdl_n + 1)) @(posedge mclk);
      chk(trig_q.size(), 32'h0, "pulses with trigger off");
      // stall freezes the joined count
      wr(OFS_CONTROL, 32'h03);
      stall_req <= 1'b1;
      rd(OFS_LOW_VAL, d2);
      repeat (5) @(posedge mclk);
      rchk(OFS_LOW_VAL, d2, "count frozen by stall");
      rchk(OFS_HIGH_VAL, {16'h0, d2[31:16]}, "joined read order");
      stall_req <= 1'b0;
      repeat (3) @(posedge mclk);
      rd(OFS_LOW_VAL, d);
      chk({31'h0, d !== d2}, 32'h1, "count resumed after stall");
      wr(OFS_CONTROL, 32'h0);
      wr(OFS_CLEAR, 32'h109);
      // split mode: low periodic untriggered, high one-shot with its own trigger and mask
      wr(OFS_CONFIG, {29'h0, CFG_16_SPLIT});
      wr(OFS_LOW_LOAD, {16'hFFFF, 16'(mdl_n)});
      rchk(OFS_LOW_LOAD, {16'h0, 16'(mdl_n)}, "split low load");
      rchk(OFS_HIGH_LOAD, 32'h0, "high load kept in split");
      wr(OFS_HIGH_LOAD, mdl_n + 5);
      wr(OFS_HIGH_MODE, {30'h0, MODE_ONESHOT});
      rchk(OFS_HIGH_MODE, {30'h0, MODE_ONESHOT}, "high mode");
      wr(OFS_MASK, 32'h100);
      trig_q.delete();
      wr(OFS_CONTROL, 32'h2101);
      repeat (3 * (mdl_n + 6) + 10) @(posedge mclk);
      chk(trig_q.size(), 32'h1, "high one-shot pulse count");
      rchk(OFS_RAW, 32'h101, "both halves timed out");
      rchk(OFS_MASKED, 32'h100, "masked high timeout");
      chk({31'h0, irq}, 32'h1, "irq on high timeout");
      rchk(OFS_CONTROL, 32'h2001, "high enable cleared");
      rchk(OFS_HIGH_VAL, 32'h0, "high one-shot stopped");
      rd(OFS_LOW_VAL, d);
      chk({16'h0, d[31:16]}, 32'h0, "split count not joined");
      // reset in mid-run brings everything back to defaults
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      rchk(OFS_CONTROL, 32'h0, "control after second reset");
      rchk(OFS_CONFIG, 32'h0, "config after second reset");
      rchk(OFS_RAW, 32'h0, "raw after second reset");
      rchk(OFS_LOW_VAL, 32'hFFFFFFFF, "count after second reset");
      chk({31'h0, irq}, 32'h0, "irq after second reset");
      // rtc with both stalls asserted: must still tick and match
      wr(OFS_LOW_MATCH, 32'h1);
      wr(OFS_MASK, 32'h8);
      wr(OFS_CONFIG, {29'h0, CFG_32_RTC});
      rchk(OFS_LOW_VAL, 32'h00000001, "rtc first load");
      wr(OFS_CONTROL, 32'h213);
      stall_req <= 1'b1;
      rtc_run <= 1'b1;
      for (i = 0; i < 70000 && irq !== 1'b1; i++) @(posedge mclk);
      chk({31'h0, irq}, 32'h1, "rtc match irq");
      rchk(OFS_RAW, 32'h8, "raw rtc flag");
      rchk(OFS_MASKED, 32'h8, "masked rtc flag");
      rchk(OFS_LOW_VAL, 32'h0, "rtc rolled to zero");
      wr(OFS_CLEAR, 32'h8);
      rchk(OFS_RAW, 32'h0, "rtc flag cleared");
      chk({31'h0, irq}, 32'h0, "irq after rtc clear");
      rtc_run <= 1'b0;
      final_report;
   end
endmodule
